/* hw/frame_slave.sv */
// slave end: decodes programming and sleep frames
// assumes master frames follow frame_if timing; one clock domain
`timescale 1ns/100ps
module frame_slave
  import cmd_pkg::*;
#(
  parameter int MEM_DEPTH = 16
)(
  input wire logic sys_clk,
  input wire logic rst,
  frame_if.slave link,
  input wire logic [5:0] own_addr,
  input wire logic wake,
  output logic asleep,
  output logic prog_done,
  output logic frame_err,
  output logic [7:0] mem_out [MEM_DEPTH]
);
  // kind of the open frame, taken from the pid at frame start
  typedef enum logic [1:0] {
    K_NONE = 2'b00,
    K_OTP = 2'b01,
    K_SLEEP = 2'b10
  } kind_t;

  // frame tracking group
  kind_t kind, next_kind; // none until a known pid opens a frame
  logic [3:0] idx, next_idx; // data bytes seen, saturating
  logic [7:0] acc, next_acc; // running sum with end-around carry
  logic ok, next_ok; // every byte so far fits the pattern
  // field latch group
  logic [3:0] ptr, next_ptr; // pointer from the third byte
  logic [7:0] val, next_val; // contents from the fourth byte
  // memory group
  logic [7:0] mem [MEM_DEPTH]; // programmable byte image
  logic [7:0] next_mem [MEM_DEPTH]; // image after this cycle
  // status group
  logic next_asleep; // sleep level, held until wake
  logic next_done; // one-cycle write pulse
  logic next_err; // one-cycle checksum pulse
  // events decoded in the current cycle
  logic data_in; // data byte of an open frame
  logic sum_in; // checksum byte of an open frame
  logic sum_ok; // checksum matches the inverted running sum
  logic byte_ok; // this data byte fits the pattern
  logic otp_good; // full programming frame, all fields good
  logic sleep_good; // full sleep frame, pattern kept

  // pid decode; pids of other commands open no frame at all
  function automatic kind_t kind_of(input logic [7:0] p);
    case (p)
      PID_OTP_WRITE: kind_of = K_OTP;
      PID_SLEEP: kind_of = K_SLEEP;
      default: kind_of = K_NONE;
    endcase
  endfunction

  // pattern of one data byte at position i of a frame of kind k;
  // the contents byte is free, so any value can be programmed
  function automatic logic fits(input kind_t k, input logic [3:0] i,
                                input logic [7:0] d,
                                input logic [5:0] a);
    fits = 1'b0;
    if (k == K_OTP) begin
      case (i)
        // own address, then the fill byte
        IDX_ADDR: fits = (d == {ADDR_MARK, a});
        IDX_FILL: fits = (d == FILL_BYTE);
        IDX_PTR: fits = (d[7:4] == PTR_MARK);
        IDX_VAL: fits = 1'b1;
        // a fifth data byte breaks the length
        default: fits = 1'b0;
      endcase
    end else if (k == K_SLEEP) begin
      if (i == COUNT_ZERO) fits = (d == SLEEP_FIRST);
      else fits = (d == FILL_BYTE);
    end
  endfunction

  // inverted end-around sum of the data bytes only
  assign sum_ok = (link.data == ~acc);
  // bytes count only inside a frame that a known pid opened;
  // start wins, though the master never sends both at once
  assign data_in = link.valid && !link.last && !link.start &&
                   (kind != K_NONE);
  assign sum_in = link.valid && link.last && !link.start &&
                  (kind != K_NONE);
  assign byte_ok = fits(kind, idx, link.data, own_addr);
  // exact length, pattern kept, good sum
  assign otp_good = sum_in && sum_ok && ok && (kind == K_OTP) &&
                    (idx == OTP_FRAME_LEN);
  // all eight bytes kept the sleep pattern
  assign sleep_good = sum_in && sum_ok && ok && (kind == K_SLEEP) &&
                      (idx == SLEEP_FRAME_LEN);

  // frame tracking: open on start, count and sum data bytes
  always_comb begin
    next_kind = kind;
    next_idx = idx;
    next_acc = acc;
    next_ok = ok;
    if (link.start) begin
      next_kind = kind_of(link.pid);
      next_idx = COUNT_ZERO;
      next_acc = BYTE_ZERO;
      next_ok = 1'b1;
    end else if (data_in) begin
      // sum covers data bytes, never the pid
      next_acc = csum_add(acc, link.data);
      // saturate so an overlong frame never wraps to a legal length
      if (idx != COUNT_FULL) next_idx = idx + COUNT_ONE;
      // one bad byte spoils the whole frame
      if (!byte_ok) next_ok = 1'b0;
    end else if (sum_in) begin
      // frame closed; stray bytes wait for the next start
      next_kind = K_NONE;
    end
  end

  // field latch: pointer and contents of a programming frame
  always_comb begin
    next_ptr = ptr;
    next_val = val;
    if (data_in && kind == K_OTP) begin
      if (idx == IDX_PTR) next_ptr = link.data[3:0];
      // contents byte, kept until the sum is checked
      if (idx == IDX_VAL) next_val = link.data;
    end
  end

  // memory: written only when the whole frame proved good
  always_comb begin
    next_mem = mem;
    // latched contents land at the pointer
    if (otp_good) next_mem[ptr] = val;
  end

  // status: sleep level and one-cycle result pulses
  always_comb begin
    // wake clears the level, a sleep frame in the same cycle wins
    next_asleep = asleep && !wake;
    // enter sleep, regardless of own address
    if (sleep_good) next_asleep = 1'b1;
    // pulse lasts one cycle, the written byte shows on mem_out
    next_done = otp_good;
    // bad sum: flagged, no other effect
    next_err = sum_in && !sum_ok;
  end

  // frame tracking registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      kind <= K_NONE;
      idx <= COUNT_ZERO;
      acc <= BYTE_ZERO;
      ok <= 1'b0;
    end else begin
      kind <= next_kind;
      idx <= next_idx;
      acc <= next_acc;
      ok <= next_ok;
    end
  end

  // field latch registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ptr <= COUNT_ZERO;
      val <= BYTE_ZERO;
    end else begin
      ptr <= next_ptr;
      val <= next_val;
    end
  end

  // memory registers; reset gives a blank image, no one-time lock
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int i = 0; i < MEM_DEPTH; i++) begin
        mem[i] <= BYTE_ZERO;
      end
    end else begin
      mem <= next_mem;
    end
  end

  // status registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      asleep <= 1'b0;
      prog_done <= 1'b0;
      frame_err <= 1'b0;
    end else begin
      asleep <= next_asleep;
      prog_done <= next_done;
      frame_err <= next_err;
    end
  end

  // image shown as it is, no read port needed
  assign mem_out = mem;
endmodule // frame_slave

/* hw/cmd_pkg.sv */
// constants shared by the frame sender and the frame decoder
// assumes one clock domain and byte-level frame transfer
package cmd_pkg;
  // protected identifiers
  localparam logic [7:0] PID_OTP_WRITE = 8'hE7;
  localparam logic [7:0] PID_SLEEP = 8'h3C;
  // data byte counts per frame type
  localparam logic [3:0] OTP_FRAME_LEN = 4'h4;
  localparam logic [3:0] SLEEP_FRAME_LEN = 4'h8;
  // fixed field values and zero and one constants
  localparam logic [1:0] ADDR_MARK = 2'h3;
  localparam logic [3:0] PTR_MARK = 4'hF;
  localparam logic [7:0] FILL_BYTE = 8'hFF;
  localparam logic [7:0] SLEEP_FIRST = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [3:0] COUNT_ZERO = 4'h0;
  localparam logic [3:0] COUNT_ONE = 4'h1;
  // byte counter ceiling, so an overlong frame cannot wrap
  localparam logic [3:0] COUNT_FULL = 4'hF;
  // data byte positions in a programming frame
  localparam logic [3:0] IDX_ADDR = 4'h0;
  localparam logic [3:0] IDX_FILL = 4'h1;
  localparam logic [3:0] IDX_PTR = 4'h2;
  localparam logic [3:0] IDX_VAL = 4'h3;
  // classic checksum: inverted sum with end-around carry
  function automatic logic [7:0] csum_add(input logic [7:0] acc,
                                          input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, acc} + {1'b0, b};
    csum_add = s[7:0] + {7'h00, s[8]};
  endfunction
endpackage

/* hw/frame_if.sv */
// byte link between master and slave command decoder
// assumes both ends share sys_clk; testbench ties them together
`timescale 1ns/100ps
interface frame_if;
  logic [7:0] pid; // protected identifier of the frame
  logic [7:0] data; // current byte (data or checksum)
  logic start; // pulse: new frame, pid valid
  logic valid; // pulse: data byte valid
  logic last; // with valid: this byte is the checksum
  modport master (output pid, output data, output start, output valid,
                  output last);
  modport slave (input pid, input data, input start, input valid,
                 input last);
endinterface

/* hw/frame_master.sv */
// master end: sends one command frame per request
// assumes user holds req inputs stable while busy
`timescale 1ns/100ps
module frame_master
  import cmd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  frame_if.master link,
  input wire logic send_otp,
  input wire logic send_sleep,
  input wire logic [5:0] node_addr,
  input wire logic [3:0] otp_ptr,
  input wire logic [7:0] otp_val,
  output logic busy
);
  typedef enum logic [1:0] {
    M_IDLE = 2'b00, M_DATA = 2'b01, M_SUM = 2'b10
  } mstate_t;
  mstate_t state, next_state; // sequencer
  logic [3:0] idx, next_idx; // byte index
  logic [7:0] acc, next_acc; // running sum
  logic is_sleep, next_is_sleep; // frame kind
  logic [7:0] cur; // byte for current index
  logic [7:0] pid, next_pid; // pid of the frame on the link
  logic [7:0] data, next_data; // byte on the link
  logic start, next_start; // frame-start pulse
  logic valid, next_valid; // byte-valid pulse
  logic last, next_last; // checksum marker

  // byte contents for each index
  always_comb begin
    cur = FILL_BYTE;
    if (is_sleep) begin
      if (idx == COUNT_ZERO) cur = SLEEP_FIRST;
    end else begin
      case (idx)
        IDX_ADDR: cur = {ADDR_MARK, node_addr};
        IDX_PTR: cur = {PTR_MARK, otp_ptr};
        IDX_VAL: cur = otp_val;
        default: cur = FILL_BYTE;
      endcase
    end
  end

  // next state of sequencer and outputs
  always_comb begin
    next_state = state;
    next_idx = idx;
    next_acc = acc;
    next_is_sleep = is_sleep;
    next_pid = pid;
    next_data = data;
    next_start = 1'b0;
    next_valid = 1'b0;
    next_last = 1'b0;
    case (state)
      M_IDLE: begin
        if (send_sleep || send_otp) begin
          next_is_sleep = send_sleep;
          next_pid = send_sleep ? PID_SLEEP : PID_OTP_WRITE;
          next_start = 1'b1;
          next_idx = COUNT_ZERO;
          next_acc = BYTE_ZERO;
          next_state = M_DATA;
        end
      end
      M_DATA: begin
        next_data = cur;
        next_valid = 1'b1;
        next_acc = csum_add(acc, cur);
        next_idx = idx + COUNT_ONE;
        if (idx + COUNT_ONE ==
            (is_sleep ? SLEEP_FRAME_LEN : OTP_FRAME_LEN))
          next_state = M_SUM;
      end
      M_SUM: begin
        next_data = ~acc;
        next_valid = 1'b1;
        next_last = 1'b1;
        next_state = M_IDLE;
      end
      default: next_state = M_IDLE;
    endcase
  end

  // registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= M_IDLE;
      idx <= COUNT_ZERO;
      acc <= BYTE_ZERO;
      is_sleep <= 1'b0;
      pid <= BYTE_ZERO;
      data <= BYTE_ZERO;
      start <= 1'b0;
      valid <= 1'b0;
      last <= 1'b0;
    end else begin
      state <= next_state;
      idx <= next_idx;
      acc <= next_acc;
      is_sleep <= next_is_sleep;
      pid <= next_pid;
      data <= next_data;
      start <= next_start;
      valid <= next_valid;
      last <= next_last;
    end
  end

  assign link.pid = pid;
  assign link.data = data;
  assign link.start = start;
  assign link.valid = valid;
  assign link.last = last;
  // busy until the checksum byte has left
  assign busy = (state != M_IDLE) || valid;
endmodule // frame_master

/* tb/lin_cmd_assertions.sv */
// checker for the byte link joining master and slave
// assumes instantiation beside the link, one clock domain
`timescale 1ns/100ps
module lin_cmd_assertions
  import cmd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] pid,
  input wire logic [7:0] data,
  input wire logic start,
  input wire logic valid,
  input wire logic last,
  input wire logic asleep,
  input wire logic prog_done
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic [7:0] acc; // running sum of data bytes
  logic [8:0] s; // raw add before carry fold
  assign s = {1'b0, acc} + {1'b0, data};
  // restart at each frame so old bytes never leak in
  always_ff @(posedge sys_clk) begin
    if (rst || start) acc <= 8'h00;
    else if (valid && !last) acc <= s[7:0] + {7'h00, s[8]};
  end
  property p_otp_len;
    start && pid == PID_OTP_WRITE |-> ##5 valid && last;
  endproperty
  a_otp_len: assert property (p_otp_len) else $error("otp length");
  property p_slp_len;
    start && pid == PID_SLEEP |-> ##9 valid && last;
  endproperty
  a_slp_len: assert property (p_slp_len) else $error("sleep length");
  property p_fields;
    start && pid == PID_OTP_WRITE |-> ##1 data[7:6] == ADDR_MARK
      ##1 data == FILL_BYTE ##1 data[7:4] == PTR_MARK;
  endproperty
  a_fields: assert property (p_fields) else $error("otp fields");
  property p_slp_pat;
    start && pid == PID_SLEEP |-> ##1 data == SLEEP_FIRST
      ##1 (data == FILL_BYTE) [*7];
  endproperty
  a_slp_pat: assert property (p_slp_pat) else $error("sleep bytes");
  property p_sum;
    valid && last |-> data == ~acc;
  endproperty
  a_sum: assert property (p_sum) else $error("checksum");
  property p_first;
    start |=> valid && !last;
  endproperty
  a_first: assert property (p_first) else $error("first byte");
  property p_done;
    prog_done |-> $past(valid && last && pid == PID_OTP_WRITE);
  endproperty
  a_done: assert property (p_done) else $error("write timing");
  property p_sleep;
    $rose(asleep) |-> $past(valid && last && pid == PID_SLEEP);
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep entry");
endmodule // lin_cmd_assertions

/* tb/test_lin_otp_program_and_sleep_cmds.sv */
// bench: master drives slave; a second slave is fed by hand
// assumes cmd_pkg, frame_if and both ends compile first
`timescale 1ns/100ps
module test_lin_otp_program_and_sleep_cmds;
  import cmd_pkg::*;
  logic sys_clk = 0, rst = 1, send_otp = 0, send_sleep = 0, wake = 0;
  logic [5:0] node_addr = 6'h00, own_addr = 6'h15;
  logic [3:0] otp_ptr = 4'h0;
  logic [7:0] otp_val = 8'h00;
  logic busy, asleep, prog_done, frame_err, asleep2, done2, err2;
  logic [7:0] mem_out [16], mem2 [16], model [16], b [8];
  int fails = 0, num_checks = 0;
  frame_if lk ();
  frame_if lk2 (); // hand-fed link for raw good and bad frames
  frame_master i_frame_master (.sys_clk, .rst, .link(lk), .send_otp,
    .send_sleep, .node_addr, .otp_ptr, .otp_val, .busy);
  frame_slave i_frame_slave (.sys_clk, .rst, .link(lk), .own_addr, .wake,
    .asleep, .prog_done, .frame_err, .mem_out);
  frame_slave i_frame_slave2 (.sys_clk, .rst, .link(lk2), .own_addr,
    .wake, .asleep(asleep2), .prog_done(done2), .frame_err(err2),
    .mem_out(mem2));
  lin_cmd_assertions i_lin_cmd_assertions (.sys_clk, .rst, .pid(lk.pid),
    .data(lk.data), .start(lk.start), .valid(lk.valid), .last(lk.last),
    .asleep, .prog_done);
  initial forever #4 sys_clk = ~sys_clk;
  task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report;
    if (fails == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // end-around carry add, written apart from the design's
  function automatic logic [7:0] fold(logic [7:0] a, logic [7:0] x);
    logic [8:0] t;
    t = {1'b0, a} + {1'b0, x};
    return t[7:0] + {7'h00, t[8]};
  endfunction
  // programming frame through the master; done shows in cycle 7
  task automatic otp(logic [5:0] a, logic [3:0] p, logic [7:0] v);
    node_addr = a;
    otp_ptr = p;
    otp_val = v;
    send_otp = 1;
    @(posedge sys_clk) #1 send_otp = 0;
    check("busy", busy, 1);
    if (a == own_addr) model[p] = v;
    repeat (6) @(posedge sys_clk);
    #1 check("prog_done", prog_done, a == own_addr);
    check("frame_err", frame_err, 0);
    check("busy", busy, 0);
    foreach (model[i]) check("mem_out", mem_out[i], model[i]);
  endtask
  // raw frame on the second link; bad flips checksum bits
  task automatic raw(logic [7:0] p, int n, logic [7:0] bad,
                     logic [2:0] exp);
    logic [7:0] acc;
    acc = 8'h00;
    lk2.pid = p;
    lk2.start = 1;
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk) #1 lk2.start = 0;
      lk2.valid = 1;
      lk2.data = b[i];
      acc = fold(acc, b[i]);
    end
    @(posedge sys_clk) #1 lk2.last = 1;
    lk2.data = ~acc ^ bad;
    @(posedge sys_clk) #1 lk2.valid = 0;
    lk2.last = 0;
    lk2.data = ~lk2.data; // released: no stale byte
    check("prog_done2", done2, exp[0]);
    check("frame_err2", err2, exp[1]);
    check("asleep2", asleep2, exp[2]);
  endtask
  initial begin
    {lk2.start, lk2.valid, lk2.last, lk2.pid, lk2.data} = '0;
    foreach (model[i]) model[i] = 8'h00;
    repeat (4) @(posedge sys_clk);
    #1 rst = 0;
    check("busy", busy, 0);
    check("asleep", asleep, 0);
    otp(6'h15, 4'h0, 8'hA5);
    otp(6'h15, 4'hF, 8'h3C);
    otp(6'h2A, 4'h3, 8'h77);
    send_sleep = 1;
    @(posedge sys_clk) #1 send_sleep = 0;
    repeat (10) @(posedge sys_clk);
    #1 check("asleep", asleep, 1);
    wake = 1;
    @(posedge sys_clk) #1 wake = 0;
    check("asleep", asleep, 0);
    b = '{8'hD5, 8'hFF, 8'hF7, 8'h5A, 8'h00, 8'h00, 8'h00, 8'h00};
    raw(PID_OTP_WRITE, 4, 8'h00, 3'b001);
    b[3] = 8'h11;
    raw(PID_OTP_WRITE, 4, 8'h01, 3'b010);
    b[2] = 8'h77;
    raw(PID_OTP_WRITE, 4, 8'h00, 3'b000);
    b[2] = 8'hF7;
    raw(PID_OTP_WRITE, 3, 8'h00, 3'b000);
    check("mem2", mem2[7], 8'h5A);
    foreach (b[i]) b[i] = i ? 8'hFF : 8'h00;
    b[7] = 8'hFE;
    raw(PID_SLEEP, 8, 8'h00, 3'b000);
    b[7] = 8'hFF;
    raw(8'h3D, 8, 8'h00, 3'b000);
    raw(PID_SLEEP, 8, 8'h00, 3'b100);
    final_report;
  end
  // watchdog: tests need about 90 cycles
  initial begin
    #20000;
    fails++;
    final_report;
  end
endmodule // test_lin_otp_program_and_sleep_cmds
